// ---- verilog/pin_ctrl_pkg.sv ----
// Package with register map, field layout and pin-control codes for the pin control block.
`default_nettype none
package pin_ctrl_pkg;
  // Bus and data widths.
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned FIELD_W = 4;
  localparam int unsigned CTRL_W = 8;
  localparam int unsigned NUM_CH = 3;
  // Channel slots: general register D and C of channel 3, B of channel 4.
  localparam int unsigned CH_D3 = 0;
  localparam int unsigned CH_C3 = 1;
  localparam int unsigned CH_B4 = 2;
  // Byte addresses of the registers.
  localparam logic [7:0] OFS_CTRL_LOW_CH3 = 8'h00;
  localparam logic [7:0] OFS_CTRL_HIGH_CH4 = 8'h04;
  localparam logic [7:0] OFS_MODE_CH3 = 8'h08;
  localparam logic [7:0] OFS_GEN_D3 = 8'h0C;
  localparam logic [7:0] OFS_GEN_C3 = 8'h10;
  localparam logic [7:0] OFS_GEN_B4 = 8'h14;
  localparam logic [7:0] OFS_PIN_STATUS = 8'h18;
  // Address bits decoded; the rest must be zero for a hit.
  localparam int unsigned DEC_W = 8;
  // Field positions inside the two control registers.
  localparam int unsigned FLD_HI_LSB = 4;
  localparam int unsigned FLD_LO_LSB = 0;
  // Buffer-mode bits in the channel 3 mode register.
  localparam int unsigned BIT_BUF_AC = 4;
  localparam int unsigned BIT_BUF_BD = 5;
  // Bits inside a 4-bit control field.
  localparam int unsigned FB_DIR = 3;
  localparam int unsigned FB_INIT = 2;
  localparam int unsigned FB_SEL1 = 1;
  localparam int unsigned FB_SEL0 = 0;
  // Match actions of the low two field bits in compare mode.
  localparam logic [1:0] ACT_HOLD = 2'h0;
  localparam logic [1:0] ACT_LOW = 2'h1;
  localparam logic [1:0] ACT_HIGH = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;
  // Reset values.
  localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
  localparam logic [CNT_W-1:0] GEN_RST = 16'hFFFF;
  // AHB transfer type and response codes.
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'h0;
endpackage : pin_ctrl_pkg
`default_nettype wire

// ---- verilog/pin_ctrl.sv ----
// Pin-function control for three timer general registers with an AHB-Lite register port.
`default_nettype none
module pin_ctrl (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_hsel,
  input wire logic [pin_ctrl_pkg::ADDR_W-1:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [pin_ctrl_pkg::DATA_W-1:0] i_hwdata,
  input wire logic i_hready,
  output logic [pin_ctrl_pkg::DATA_W-1:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  input wire logic [pin_ctrl_pkg::CNT_W-1:0] i_count,
  input wire logic [pin_ctrl_pkg::NUM_CH-1:0] i_match,
  input wire logic [pin_ctrl_pkg::NUM_CH-1:0] i_pin,
  output logic [pin_ctrl_pkg::NUM_CH-1:0] o_pin,
  output logic [pin_ctrl_pkg::NUM_CH-1:0] o_pin_oe_n,
  output logic [pin_ctrl_pkg::NUM_CH-1:0] o_capture
);

  // True when a field selects input capture.
  function automatic logic is_capture(input logic [pin_ctrl_pkg::FIELD_W-1:0] f);
    is_capture = f[pin_ctrl_pkg::FB_DIR];
  endfunction : is_capture

  // True when a field selects compare with an initial level (not output hold).
  function automatic logic is_compare(input logic [pin_ctrl_pkg::FIELD_W-1:0] f);
    is_compare = !f[pin_ctrl_pkg::FB_DIR] &&
      (f[pin_ctrl_pkg::FB_SEL1:pin_ctrl_pkg::FB_SEL0] != pin_ctrl_pkg::ACT_HOLD);
  endfunction : is_compare

  // Control and mode registers.
  logic [pin_ctrl_pkg::CTRL_W-1:0] ctrl_lo_q, ctrl_lo_d; // Fields D and C of channel 3.
  logic [pin_ctrl_pkg::CTRL_W-1:0] ctrl_hi_q, ctrl_hi_d; // Field B of channel 4 in upper nibble.
  logic buf_ac_q, buf_ac_d; // Register C of channel 3 serves as a buffer.
  logic buf_bd_q, buf_bd_d; // Register D of channel 3 serves as a buffer.
  // General registers loaded by capture or by software.
  logic [pin_ctrl_pkg::CNT_W-1:0] gen_q [pin_ctrl_pkg::NUM_CH];
  logic [pin_ctrl_pkg::CNT_W-1:0] gen_d [pin_ctrl_pkg::NUM_CH];
  // Bus data-phase state.
  logic wr_pend_q, wr_pend_d; // A write data phase is due this cycle.
  logic [pin_ctrl_pkg::DEC_W-1:0] wr_addr_q, wr_addr_d; // Byte address of that write.
  logic [pin_ctrl_pkg::DATA_W-1:0] rdata_q, rdata_d; // Read data for the data phase.
  logic ready_q; // Always ready, under reset as well.
  // Pin synchronisers and edge history.
  logic [pin_ctrl_pkg::NUM_CH-1:0] pin_s1_q, pin_s2_q, pin_s3_q;
  // Pin driver state.
  logic [pin_ctrl_pkg::NUM_CH-1:0] pin_q, pin_d, oe_n_q, oe_n_d, cap_q, cap_d;
  // Per-channel views built from the registers.
  logic [pin_ctrl_pkg::FIELD_W-1:0] fld [pin_ctrl_pkg::NUM_CH];
  logic [pin_ctrl_pkg::FIELD_W-1:0] fld_new [pin_ctrl_pkg::NUM_CH];
  logic [pin_ctrl_pkg::NUM_CH-1:0] ch_off, ch_off_new, fld_written;
  logic addr_ok;

  // Field slots of the stored and the incoming settings.
  always_comb
  begin
    fld[pin_ctrl_pkg::CH_D3] = ctrl_lo_q[pin_ctrl_pkg::FLD_HI_LSB +: pin_ctrl_pkg::FIELD_W];
    fld[pin_ctrl_pkg::CH_C3] = ctrl_lo_q[pin_ctrl_pkg::FLD_LO_LSB +: pin_ctrl_pkg::FIELD_W];
    fld[pin_ctrl_pkg::CH_B4] = ctrl_hi_q[pin_ctrl_pkg::FLD_HI_LSB +: pin_ctrl_pkg::FIELD_W];
    fld_new[pin_ctrl_pkg::CH_D3] = ctrl_lo_d[pin_ctrl_pkg::FLD_HI_LSB +: pin_ctrl_pkg::FIELD_W];
    fld_new[pin_ctrl_pkg::CH_C3] = ctrl_lo_d[pin_ctrl_pkg::FLD_LO_LSB +: pin_ctrl_pkg::FIELD_W];
    fld_new[pin_ctrl_pkg::CH_B4] = ctrl_hi_d[pin_ctrl_pkg::FLD_HI_LSB +: pin_ctrl_pkg::FIELD_W];
    ch_off[pin_ctrl_pkg::CH_D3] = buf_bd_q;
    ch_off[pin_ctrl_pkg::CH_C3] = buf_ac_q;
    ch_off[pin_ctrl_pkg::CH_B4] = 1'b0;
    ch_off_new[pin_ctrl_pkg::CH_D3] = buf_bd_d;
    ch_off_new[pin_ctrl_pkg::CH_C3] = buf_ac_d;
    ch_off_new[pin_ctrl_pkg::CH_B4] = 1'b0;
    // A field counts as written when its register is the target of this data phase.
    fld_written[pin_ctrl_pkg::CH_D3] = wr_pend_q &&
      (wr_addr_q == pin_ctrl_pkg::OFS_CTRL_LOW_CH3);
    fld_written[pin_ctrl_pkg::CH_C3] = fld_written[pin_ctrl_pkg::CH_D3];
    fld_written[pin_ctrl_pkg::CH_B4] = wr_pend_q &&
      (wr_addr_q == pin_ctrl_pkg::OFS_CTRL_HIGH_CH4);
  end

  // Register writes land in the data phase; capture loads of general registers win
  // over a software write in the same cycle, since the event must not be lost.
  always_comb
  begin
    ctrl_lo_d = ctrl_lo_q;
    ctrl_hi_d = ctrl_hi_q;
    buf_ac_d = buf_ac_q;
    buf_bd_d = buf_bd_q;
    gen_d = gen_q;
    if (wr_pend_q)
    begin
      if (wr_addr_q == pin_ctrl_pkg::OFS_CTRL_LOW_CH3)
      begin
        ctrl_lo_d = i_hwdata[pin_ctrl_pkg::CTRL_W-1:0];
      end
      else if (wr_addr_q == pin_ctrl_pkg::OFS_CTRL_HIGH_CH4)
      begin
        ctrl_hi_d = i_hwdata[pin_ctrl_pkg::CTRL_W-1:0];
      end
      else if (wr_addr_q == pin_ctrl_pkg::OFS_MODE_CH3)
      begin
        buf_ac_d = i_hwdata[pin_ctrl_pkg::BIT_BUF_AC];
        buf_bd_d = i_hwdata[pin_ctrl_pkg::BIT_BUF_BD];
      end
      else if (wr_addr_q == pin_ctrl_pkg::OFS_GEN_D3)
      begin
        gen_d[pin_ctrl_pkg::CH_D3] = i_hwdata[pin_ctrl_pkg::CNT_W-1:0];
      end
      else if (wr_addr_q == pin_ctrl_pkg::OFS_GEN_C3)
      begin
        gen_d[pin_ctrl_pkg::CH_C3] = i_hwdata[pin_ctrl_pkg::CNT_W-1:0];
      end
      else if (wr_addr_q == pin_ctrl_pkg::OFS_GEN_B4)
      begin
        gen_d[pin_ctrl_pkg::CH_B4] = i_hwdata[pin_ctrl_pkg::CNT_W-1:0];
      end
    end
    for (int i = 0; i < pin_ctrl_pkg::NUM_CH; i++)
    begin
      if (cap_d[i])
      begin
        gen_d[i] = i_count;
      end
    end
  end

  // Pin drive, match actions and capture edge selection per channel.
  always_comb
  begin
    pin_d = pin_q;
    oe_n_d = oe_n_q;
    cap_d = '0;
    for (int i = 0; i < pin_ctrl_pkg::NUM_CH; i++)
    begin
      if (ch_off[i])
      begin
        cap_d[i] = 1'b0;
      end
      else if (is_capture(fld[i]))
      begin
        // Capture mode releases the pin and watches its synchronised level.
        oe_n_d[i] = 1'b1;
        if (fld[i][pin_ctrl_pkg::FB_SEL1])
        begin
          cap_d[i] = pin_s2_q[i] ^ pin_s3_q[i];
        end
        else if (fld[i][pin_ctrl_pkg::FB_SEL0])
        begin
          cap_d[i] = !pin_s2_q[i] && pin_s3_q[i];
        end
        else
        begin
          cap_d[i] = pin_s2_q[i] && !pin_s3_q[i];
        end
      end
      else
      begin
        // Compare or hold: the block drives the pin.
        oe_n_d[i] = 1'b0;
        if (i_match[i])
        begin
          case (fld[i][pin_ctrl_pkg::FB_SEL1:pin_ctrl_pkg::FB_SEL0])
            pin_ctrl_pkg::ACT_LOW: pin_d[i] = 1'b0;
            pin_ctrl_pkg::ACT_HIGH: pin_d[i] = 1'b1;
            pin_ctrl_pkg::ACT_TOGGLE: pin_d[i] = !pin_q[i];
            default: pin_d[i] = pin_q[i];
          endcase
        end
      end
      // A fresh compare setting overrides a match in the same cycle, because the
      // new setting defines the starting level software asked for.
      if (fld_written[i] && !ch_off_new[i] && is_compare(fld_new[i]))
      begin
        pin_d[i] = fld_new[i][pin_ctrl_pkg::FB_INIT];
        oe_n_d[i] = 1'b0;
      end
    end
  end

  // Address phase decode: low byte selects the register, upper bits must be zero; writes outside the map are dropped.
  always_comb
  begin
    addr_ok = (i_haddr[pin_ctrl_pkg::ADDR_W-1:pin_ctrl_pkg::DEC_W] == '0);
    wr_pend_d = addr_ok && i_hsel && i_hready && (i_htrans == pin_ctrl_pkg::HTRANS_NONSEQ) &&
      i_hwrite;
    wr_addr_d = i_haddr[pin_ctrl_pkg::DEC_W-1:0];
    rdata_d = '0;
    // Reads use next-state values so a read right after a write sees the new value.
    if (i_hsel && i_hready && (i_htrans == pin_ctrl_pkg::HTRANS_NONSEQ) && !i_hwrite && addr_ok)
    begin
      if (wr_addr_d == pin_ctrl_pkg::OFS_CTRL_LOW_CH3)
      begin
        rdata_d[pin_ctrl_pkg::CTRL_W-1:0] = ctrl_lo_d;
      end
      else if (wr_addr_d == pin_ctrl_pkg::OFS_CTRL_HIGH_CH4)
      begin
        rdata_d[pin_ctrl_pkg::CTRL_W-1:0] = ctrl_hi_d;
      end
      else if (wr_addr_d == pin_ctrl_pkg::OFS_MODE_CH3)
      begin
        rdata_d[pin_ctrl_pkg::BIT_BUF_AC] = buf_ac_d;
        rdata_d[pin_ctrl_pkg::BIT_BUF_BD] = buf_bd_d;
      end
      else if (wr_addr_d == pin_ctrl_pkg::OFS_GEN_D3)
      begin
        rdata_d[pin_ctrl_pkg::CNT_W-1:0] = gen_d[pin_ctrl_pkg::CH_D3];
      end
      else if (wr_addr_d == pin_ctrl_pkg::OFS_GEN_C3)
      begin
        rdata_d[pin_ctrl_pkg::CNT_W-1:0] = gen_d[pin_ctrl_pkg::CH_C3];
      end
      else if (wr_addr_d == pin_ctrl_pkg::OFS_GEN_B4)
      begin
        rdata_d[pin_ctrl_pkg::CNT_W-1:0] = gen_d[pin_ctrl_pkg::CH_B4];
      end
      else if (wr_addr_d == pin_ctrl_pkg::OFS_PIN_STATUS)
      begin
        // Driven level, then synchronised pin level, three bits each.
        rdata_d[pin_ctrl_pkg::NUM_CH-1:0] = pin_d;
        rdata_d[2*pin_ctrl_pkg::NUM_CH-1:pin_ctrl_pkg::NUM_CH] = pin_s2_q;
      end
    end
  end

  // State registers; every flop takes a constant under reset.
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      ctrl_lo_q <= pin_ctrl_pkg::CTRL_RST;
      ctrl_hi_q <= pin_ctrl_pkg::CTRL_RST;
      buf_ac_q <= 1'b0;
      buf_bd_q <= 1'b0;
      gen_q <= '{default: pin_ctrl_pkg::GEN_RST};
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
      rdata_q <= '0;
      ready_q <= 1'b1;
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      pin_s3_q <= '0;
      pin_q <= '0;
      oe_n_q <= '0;
      cap_q <= '0;
    end
    else
    begin
      ctrl_lo_q <= ctrl_lo_d;
      ctrl_hi_q <= ctrl_hi_d;
      buf_ac_q <= buf_ac_d;
      buf_bd_q <= buf_bd_d;
      gen_q <= gen_d;
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
      rdata_q <= rdata_d;
      ready_q <= 1'b1;
      // Two-stage synchroniser; the third stage only serves edge detection.
      pin_s1_q <= i_pin;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_q <= pin_d;
      oe_n_q <= oe_n_d;
      cap_q <= cap_d;
    end
  end

  // Outputs come straight from flops, except o_hresp, which is tied to OKAY.
  assign o_hrdata = rdata_q;
  assign o_hreadyout = ready_q;
  assign o_hresp = pin_ctrl_pkg::HRESP_OKAY;
  assign o_pin = pin_q;
  assign o_pin_oe_n = oe_n_q;
  assign o_capture = cap_q;
endmodule : pin_ctrl
`default_nettype wire

// ---- verification/pin_far_end.sv ----
// Board-side model of the three timer pins.
`default_nettype none
module pin_far_end (
  input wire logic [2:0] i_out,
  input wire logic [2:0] i_oe_n,
  input wire logic [2:0] i_drv,
  output logic [2:0] o_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // A pin shows the block's level while it drives, else the board's level.
  assign o_level = (~i_oe_n & i_out) | (i_oe_n & i_drv);
endmodule : pin_far_end
`default_nettype wire

// ---- verification/pin_ctrl_monitor.sv ----
// Checker for the pin control block ports.
`default_nettype none
module pin_ctrl_monitor (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  input wire logic [31:0] o_hrdata,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  input wire logic [15:0] i_count,
  input wire logic [2:0] i_match,
  input wire logic [2:0] i_pin,
  input wire logic [2:0] o_pin,
  input wire logic [2:0] o_pin_oe_n,
  input wire logic [2:0] o_capture
);
  timeunit 1ns;
  timeprecision 1ps;
  logic w_q;  // Write data phase under way.
  logic [7:0] a_q;  // Address taken in the last address phase.
  logic [7:0] lo_q;  // Shadow of the low control register.
  logic [7:0] md_q;  // Shadow of the mode register.
  // Shadows update at the same edge as the real registers.
  always_ff @(posedge i_clk)
  begin
    w_q <= !i_rst && i_hsel && i_hready && i_htrans == 2'h2 && i_hwrite;
    a_q <= i_haddr[7:0];
    lo_q <= i_rst ? 8'h00 : (w_q && a_q == 8'h00) ? i_hwdata[7:0] : lo_q;
    md_q <= i_rst ? 8'h00 : (w_q && a_q == 8'h08) ? i_hwdata[7:0] : md_q;
  end
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  sequence s_d_match;
    !w_q && i_match[0] && !md_q[5] && !lo_q[7] && lo_q[5:4] != 2'h0;
  endsequence
  sequence s_d_cmp_wr;
    w_q && a_q == 8'h00 && !i_hwdata[7] && i_hwdata[5:4] != 2'h0 && !md_q[5];
  endsequence
  property p_rst_low;
    disable iff (1'b0) i_rst |=> o_pin == 3'h0 && o_pin_oe_n == 3'h0;
  endproperty
  a_rst_low: assert property (p_rst_low) else $error("pins not low after reset");
  property p_hold;
    !w_q && i_match == 3'h0 |=> $stable(o_pin);
  endproperty
  a_hold: assert property (p_hold) else $error("pin moved without cause");
  property p_act;
    s_d_match |=> o_pin[0] == (lo_q[5:4] == 2'h3 ? !$past(o_pin[0]) : lo_q[5]);
  endproperty
  a_act: assert property (p_act) else $error("wrong match action");
  property p_init;
    s_d_cmp_wr |=> o_pin[0] == $past(i_hwdata[6]) && !o_pin_oe_n[0];
  endproperty
  a_init: assert property (p_init) else $error("initial level not applied");
  property p_cap_oe;
    w_q && a_q == 8'h00 && i_hwdata[3] && !md_q[4] |-> ##2 o_pin_oe_n[1];
  endproperty
  a_cap_oe: assert property (p_cap_oe) else $error("capture pin still driven");
  property p_cap_src;
    (o_capture & ~($past(i_pin, 3) ^ $past(i_pin, 4))) == 3'h0;
  endproperty
  a_cap_src: assert property (p_cap_src) else $error("capture without pin edge");
  property p_buf_d;
    md_q[5] && !w_q && i_match[0] |=> $stable(o_pin[0]);
  endproperty
  a_buf_d: assert property (p_buf_d) else $error("buffer pin acted on match");
  property p_buf_c;
    md_q[4] && $past(md_q[4]) |-> !o_capture[1];
  endproperty
  a_buf_c: assert property (p_buf_c) else $error("buffer register captured");
endmodule : pin_ctrl_monitor
bind pin_ctrl pin_ctrl_monitor u_pin_ctrl_monitor (.i_clk, .i_rst, .i_hsel, .i_haddr,
  .i_htrans, .i_hwrite, .i_hsize, .i_hwdata, .i_hready, .o_hrdata, .o_hreadyout, .o_hresp,
  .i_count, .i_match, .i_pin, .o_pin, .o_pin_oe_n, .o_capture);
`default_nettype wire

// ---- verification/capture_compare_pin_io_control_tb.sv ----
// Self-checking bench for the pin control block.
`default_nettype none
module capture_compare_pin_io_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk, i_rst, hsel, hwrite, hrdy, hresp, mp;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rd_q;
  logic [15:0] cnt, c16;
  logic [2:0] match, drv, lvl, pin, oe_n, cap;
  int seed, mismatches, checks_done;
  pin_ctrl u_pin_ctrl (.i_clk(i_clk), .i_rst(i_rst), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hrdy),
    .o_hrdata(hrdata), .o_hreadyout(hrdy), .o_hresp(hresp), .i_count(cnt), .i_match(match),
    .i_pin(lvl), .o_pin(pin), .o_pin_oe_n(oe_n), .o_capture(cap));
  pin_far_end u_pin_far_end (.i_out(pin), .i_oe_n(oe_n), .i_drv(drv), .o_level(lvl));
  // Free-running counter; read data is taken at the edge ending the data phase.
  // The counter restarts from a random value under reset, so it has one driver.
  always @(posedge i_clk)
  begin
    if (i_rst)
      cnt <= 16'($random(seed));
    else
      cnt <= cnt + 16'h1;
    rd_q <= hrdata;
  end
  initial
  begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      mismatches++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up
  // One single AHB transfer; each phase waits for ready under a bound.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge i_clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= pin_ctrl_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    for (int p = 0; p < 2; p++)
    begin
      n = 0;
      do
      begin
        @(posedge i_clk);
        n++;
      end while (hrdy !== 1'b1 && n < 50);
      if (n >= 50)
      begin
        mismatches++;
        wrap_up();
      end
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
    end
    #1;
    // The slave never signals an error.
    chk(32'(hresp), 32'(pin_ctrl_pkg::HRESP_OKAY));
  endtask : bus
  task automatic pulse(input logic [2:0] m);
    @(posedge i_clk);
    match <= m;
    @(posedge i_clk);
    match <= 3'h0;
    #1;
  endtask : pulse
  // Moves the D pin and expects a capture three edges later, or none.
  task automatic edge_chk(input logic l, input logic e);
    @(posedge i_clk);
    drv <= {2'h0, l};
    #1;
    c16 = cnt + 16'h2;
    repeat (3) @(posedge i_clk);
    #1;
    chk(32'(cap[0]), 32'(e));
    if (e)
    begin
      bus(1'b0, 8'h0C, 32'h0);
      chk(rd_q, {16'h0, c16});
    end
  endtask : edge_chk
  initial
  begin
    seed = 32'h5D71;
    i_rst = 1'b1;
    {hsel, hwrite, htrans, haddr, hwdata, match, drv} = '0;
    mp = 1'b0;
    mismatches = 0;
    checks_done = 0;
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    #1;
    chk(32'({oe_n, pin}), 32'h0);
    bus(1'b0, 8'h0C, 32'h0);
    chk(rd_q, 32'h0000FFFF);
    // Every field code on all three fields, then a match on each pin.
    for (int c = 0; c < 16; c++)
    begin
      bus(1'b1, 8'h00, 32'(c * 17));
      bus(1'b1, 8'h04, 32'(c * 16));
      if (!c[3] && c[1:0] != 2'h0)
        mp = c[2];
      // A capture field releases its pin one edge after the field lands.
      @(posedge i_clk);
      #1;
      chk(c[3] ? 32'(oe_n) : 32'({oe_n, pin}), c[3] ? 32'h7 : 32'({3'h0, {3{mp}}}));
      pulse(3'h7);
      if (!c[3] && c[1:0] != 2'h0)
        mp = c[1:0] == 2'h3 ? !mp : c[1];
      if (!c[3])
        chk(32'({oe_n, pin}), 32'({3'h0, {3{mp}}}));
    end
    for (int k = 8; k < 12; k++)
    begin
      bus(1'b1, 8'h00, 32'(k * 16));
      repeat (5) @(posedge i_clk);
      edge_chk(1'b1, k != 9);
      edge_chk(1'b0, k != 8);
    end
    c16 = 16'($random(seed));
    bus(1'b1, 8'h10, {16'h0, c16});
    bus(1'b0, 8'h10, 32'h0);
    chk(rd_q, {16'h0, c16});
    bus(1'b1, 8'h00, 32'h33);
    bus(1'b1, 8'h08, 32'h30);
    pulse(3'h3);
    chk(32'(pin[1:0]), 32'h0);
    bus(1'b1, 8'h08, 32'h0);
    pulse(3'h3);
    chk(32'(pin[1:0]), 32'h3);
    bus(1'b1, 8'h40, 32'hFF);
    bus(1'b0, 8'h40, 32'h0);
    chk(rd_q, 32'h0);
    bus(1'b0, 8'h00, 32'h0);
    chk(rd_q, 32'h33);
    // Status: driven levels 011 and seen levels 011, the released B pin pulled low.
    bus(1'b0, pin_ctrl_pkg::OFS_PIN_STATUS, 32'h0);
    chk(rd_q, 32'h0000001B);
    @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    #1;
    chk(32'({oe_n, pin}), 32'h0);
    wrap_up();
  end
  // Cuts a hang short.
  initial
  begin
    repeat (20000) @(posedge i_clk);
    mismatches++;
    wrap_up();
  end
endmodule : capture_compare_pin_io_control_tb
`default_nettype wire
